// >>> src/rdsw_pkg.sv
/*
  Package for the random delay switch: widths, timebase codes, source
  selection, reset values and the configuration carrier struct.
  Assumes a single 100 MHz system clock.
*/
package rdsw_pkg;
  // ****************************************************************
  // Widths and clock
  // ****************************************************************
  localparam int          RDSW_DW        = 16;
  localparam int          RDSW_BLK_W     = 4;
  localparam int          RDSW_NBLK      = 16;
  localparam int          RDSW_CLK_MHZ   = 100;
  localparam int          RDSW_LFSR_W    = 16;
  localparam logic [15:0] RDSW_LFSR_SEED = 16'hace1;
  localparam logic [15:0] RDSW_LFSR_TAPS = 16'hb400;

  // ****************************************************************
  // Timebase: tick periods in microseconds, then in clock cycles
  // ****************************************************************
  localparam int RDSW_TB_10MS_US = 10000;
  localparam int RDSW_TB_S_US    = 1000000;
  localparam int RDSW_TB_MIN_US  = 60000000;
  localparam int RDSW_TB_10MS_CYC = RDSW_TB_10MS_US * RDSW_CLK_MHZ;
  localparam int RDSW_TB_S_CYC    = RDSW_TB_S_US * RDSW_CLK_MHZ;
  localparam longint RDSW_TB_MIN_CYC =
    longint'(RDSW_TB_MIN_US) * longint'(RDSW_CLK_MHZ);
  localparam int RDSW_PRE_W = 33;

  typedef enum logic [1:0] {
    RDSW_TB_10MS = 2'h0,
    RDSW_TB_SEC  = 2'h1,
    RDSW_TB_MIN  = 2'h2,
    RDSW_TB_HOUR = 2'h3
  } rdsw_tb_e;

  localparam logic [RDSW_DW-1:0] RDSW_ZERO    = 16'h0000;
  localparam logic [RDSW_DW-1:0] RDSW_ONE     = 16'h0001;
  localparam logic [5:0]         RDSW_MIN_HR  = 6'h3b;

  // One maximum: fixed value or another block's actual value
  typedef struct packed {
    logic                  use_blk;
    logic [RDSW_BLK_W-1:0] blk_num;
    logic [RDSW_DW-1:0]    fixed;
  } rdsw_max_s;

  typedef struct packed {
    rdsw_tb_e  timebase;
    rdsw_max_s on_max;
    rdsw_max_s off_max;
  } rdsw_cfg_s;
endpackage : rdsw_pkg

// >>> src/rdsw_switch.sv
/*
  Random delay switch: drives one output from an enable input through
  random on and off delays. Assumes EN_IN comes from another block on
  the same clock, and block actual values arrive as a flat bus.
*/
// What this block does
// R1: Enable rising edge starts an on-delay of random length, zero to max.
// R2: Output goes high at on-delay expiry if enable stayed high throughout.
// R3: Enable falling during the on-delay clears elapsed time; output not set.
// R4: Enable falling edge starts an off-delay of random length, zero to max.
// R5: Output goes low at off-delay expiry if enable stayed low throughout.
// R6: Enable rising during the off-delay clears elapsed time; output kept.
// R7: After reset the elapsed delay time is zero.
// R8: Each maximum is a fixed value or another block's live actual value.
// R9: One selectable timebase applies to both maxima.
// R10: Random delays come from a free-running LFSR scaled into zero..max.
// R11: Count one unit per tick; edges compare with the level at last tick.
module rdsw_switch
  import rdsw_pkg::*;
#(
  parameter int     DW          = RDSW_DW,
  parameter int     NBLK        = RDSW_NBLK,
  parameter longint TB_10MS_CYC = RDSW_TB_10MS_CYC,
  parameter longint TB_S_CYC    = RDSW_TB_S_CYC,
  parameter longint TB_MIN_CYC  = RDSW_TB_MIN_CYC
)(
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  SYS_RST_IN,
  input  wire logic                  EN_IN,
  input  wire rdsw_pkg::rdsw_cfg_s   CFG_IN,
  input  wire logic [NBLK*DW-1:0]    BLK_VALUES_IN,
  output logic                       SWITCH_OUT,
  output logic [DW-1:0]              ELAPSED_TIME_OUT,
  output logic                       DELAY_BUSY_OUT
);
  import rdsw_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ON   = 3'b010,
    ST_OFF  = 3'b100
  } rdsw_st_e;

  // ****************************************************************
  // Maximum selection
  // ****************************************************************
  // Live value is taken each cycle, but it only sets the target when a delay starts
  function automatic logic [DW-1:0] pick_max(
    input rdsw_max_s          m,
    input logic [NBLK*DW-1:0] vals
  );
    logic [DW-1:0] v;
    v = m.fixed[DW-1:0];
    if (m.use_blk)
      v = vals[m.blk_num*DW +: DW];
    return v;
  endfunction : pick_max

  logic [DW-1:0] on_max;
  logic [DW-1:0] off_max;
  assign on_max  = pick_max(CFG_IN.on_max, BLK_VALUES_IN);   // [R8]
  assign off_max = pick_max(CFG_IN.off_max, BLK_VALUES_IN);  // [R8]

  // ****************************************************************
  // Timebase tick
  // ****************************************************************
  logic     tick;
  logic     tick_clr;
  rdsw_tb_e tb_prev;
  rdsw_tb_e next_tb_prev;

  // Restart the prescaler when the timebase changes, so a count left
  // over from the old base cannot cut the first new period short
  assign tick_clr = (CFG_IN.timebase != tb_prev);            // [R9]

  rdsw_tick #(
    .TB_10MS_CYC (TB_10MS_CYC),
    .TB_S_CYC    (TB_S_CYC),
    .TB_MIN_CYC  (TB_MIN_CYC)
  ) u_tick (
    .clk_in   (CLK_SYS_IN),
    .rst_in   (SYS_RST_IN),
    .tb_in    (CFG_IN.timebase),                             // [R9]
    .clr_in   (tick_clr),
    .tick_out (tick)
  );

  // ****************************************************************
  // Random source
  // ****************************************************************
  logic [RDSW_LFSR_W-1:0] lfsr;
  logic [RDSW_LFSR_W-1:0] next_lfsr;

  always_comb
  begin
    next_lfsr = lfsr >> 1;                                   // [R10]
    if (lfsr[0])
      next_lfsr = (lfsr >> 1) ^ RDSW_LFSR_TAPS;
  end

  // Multiply then keep the top bits: result stays within 0..max
  function automatic logic [DW-1:0] scale(
    input logic [DW-1:0]          mx,
    input logic [RDSW_LFSR_W-1:0] r
  );
    logic [DW+RDSW_LFSR_W:0] p;
    p = {1'b0, mx} * {1'b0, r} + {1'b0, mx};
    return p[DW+RDSW_LFSR_W-1 -: DW];
  endfunction : scale

  // ****************************************************************
  // Delay state machine
  // ****************************************************************
  rdsw_st_e      st;
  rdsw_st_e      next_st;
  logic          en_prev;
  logic          next_en_prev;
  logic [DW-1:0] elapsed;
  logic [DW-1:0] next_elapsed;
  logic [DW-1:0] target;
  logic [DW-1:0] next_target;
  logic          next_switch;
  logic          rise;
  logic          fall;

  // Edges are seen on the tick, so pulses that start and end between two ticks are missed
  assign rise     = tick & EN_IN & ~en_prev;                 // [R11]
  assign fall     = tick & ~EN_IN & en_prev;                 // [R11]

  always_comb
  begin
    next_st      = st;
    next_en_prev = en_prev;
    next_tb_prev = CFG_IN.timebase;
    next_elapsed = elapsed;
    next_target  = target;
    next_switch  = SWITCH_OUT;
    if (tick)
      next_en_prev = EN_IN;
    case (st)
      ST_IDLE:
      begin
        if (rise)
        begin
          next_st      = ST_ON;                              // [R1]
          next_target  = scale(on_max, lfsr);                // [R1]
          next_elapsed = RDSW_ZERO;
        end
        else if (fall)
        begin
          next_st      = ST_OFF;                             // [R4]
          next_target  = scale(off_max, lfsr);               // [R4]
          next_elapsed = RDSW_ZERO;
        end
      end
      ST_ON:
      begin
        if (fall)
        begin
          next_elapsed = RDSW_ZERO;                          // [R3]
          next_st      = ST_OFF;
          next_target  = scale(off_max, lfsr);               // [R4]
        end
        else if (tick)
        begin
          if (elapsed >= target)
          begin
            next_switch  = 1'b1;                             // [R2]
            next_st      = ST_IDLE;
            next_elapsed = RDSW_ZERO;
          end
          else
            next_elapsed = elapsed + RDSW_ONE;               // [R11]
        end
      end
      ST_OFF:
      begin
        if (rise)
        begin
          next_elapsed = RDSW_ZERO;                          // [R6]
          next_st      = ST_ON;
          next_target  = scale(on_max, lfsr);                // [R1]
        end
        else if (tick)
        begin
          if (elapsed >= target)
          begin
            next_switch  = 1'b0;                             // [R5]
            next_st      = ST_IDLE;
            next_elapsed = RDSW_ZERO;
          end
          else
            next_elapsed = elapsed + RDSW_ONE;               // [R11]
        end
      end
      default:
      begin
        next_st      = ST_IDLE;
        next_elapsed = RDSW_ZERO;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      st               <= ST_IDLE;
      en_prev          <= 1'b0;
      elapsed          <= RDSW_ZERO;                         // [R7]
      target           <= RDSW_ZERO;
      SWITCH_OUT       <= 1'b0;
      ELAPSED_TIME_OUT <= RDSW_ZERO;                         // [R7]
      DELAY_BUSY_OUT   <= 1'b0;
      lfsr             <= RDSW_LFSR_SEED;
      tb_prev          <= RDSW_TB_10MS;
    end
    else
    begin
      st               <= next_st;
      en_prev          <= next_en_prev;
      elapsed          <= next_elapsed;
      target           <= next_target;
      SWITCH_OUT       <= next_switch;
      ELAPSED_TIME_OUT <= next_elapsed;
      DELAY_BUSY_OUT   <= (next_st != ST_IDLE);
      lfsr             <= next_lfsr;
      tb_prev          <= next_tb_prev;
    end
  end
endmodule : rdsw_switch

// >>> src/rdsw_tick.sv
/*
  Timebase tick generator: one-cycle pulse per timebase unit.
  Assumes the timebase code is steady while a delay runs.
*/
module rdsw_tick
  import rdsw_pkg::*;
#(
  parameter longint TB_10MS_CYC = RDSW_TB_10MS_CYC,
  parameter longint TB_S_CYC    = RDSW_TB_S_CYC,
  parameter longint TB_MIN_CYC  = RDSW_TB_MIN_CYC
)(
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire rdsw_pkg::rdsw_tb_e tb_in,
  input  wire logic            clr_in,
  output logic                 tick_out
);
  // ****************************************************************
  // Prescaler and minute counter for the hour base
  // ****************************************************************
  logic [RDSW_PRE_W-1:0] pre;
  logic [RDSW_PRE_W-1:0] next_pre;
  logic [5:0]            mins;
  logic [5:0]            next_mins;
  logic                  next_tick;
  logic [RDSW_PRE_W-1:0] lim;

  always_comb
  begin
    lim = RDSW_PRE_W'(TB_MIN_CYC - 1);
    case (tb_in)
      RDSW_TB_10MS: lim = RDSW_PRE_W'(TB_10MS_CYC - 1);
      RDSW_TB_SEC:  lim = RDSW_PRE_W'(TB_S_CYC - 1);
      default:      lim = RDSW_PRE_W'(TB_MIN_CYC - 1);
    endcase
    next_pre  = pre + RDSW_PRE_W'(1);
    next_mins = mins;
    next_tick = 1'b0;
    if (clr_in)
    begin
      next_pre  = '0;
      next_mins = '0;
    end
    else if (pre >= lim)
    begin
      next_pre = '0;
      if (tb_in != RDSW_TB_HOUR)
        next_tick = 1'b1;
      else if (mins >= RDSW_MIN_HR)
      begin
        next_mins = '0;
        next_tick = 1'b1;
      end
      else
        next_mins = mins + 6'h01;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pre      <= '0;
      mins     <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      pre      <= next_pre;
      mins     <= next_mins;
      tick_out <= next_tick;
    end
  end
endmodule : rdsw_tick

// >>> tb/rdsw_en_src.sv
/*
  Upstream controller blocks: the enable level and block actual values.
  Assumes the bench requests a level with a non-blocking write.
*/
module rdsw_en_src
  import rdsw_pkg::*;
#(
  parameter int DW       = RDSW_DW,
  parameter int NBLK     = RDSW_NBLK,
  parameter int ZERO_BLK = 9
)(
  input  wire logic          clk_in,
  input  wire logic          want_in,
  output logic               en_out,
  output logic [NBLK*DW-1:0] blk_values_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level changes only at a falling edge, one cycle after the request
  always @(negedge clk_in) en_out <= want_in;
  // One block reads zero, all others full scale, so a wrong pick shows
  always_comb
  begin
    blk_values_out = '1;
    blk_values_out[ZERO_BLK*DW +: DW] = '0;
  end
endmodule : rdsw_en_src

// >>> tb/rdsw_switch_assertions.sv
/*
  Port checker for rdsw_switch, bound into every instance.
  Assumes timebase ticks are at least four clock cycles apart.
*/
module rdsw_switch_assertions
  import rdsw_pkg::*;
#(
  parameter int DW = RDSW_DW
)(
  input wire logic          CLK_SYS_IN,
  input wire logic          SYS_RST_IN,
  input wire logic          EN_IN,
  input wire logic          SWITCH_OUT,
  input wire logic [DW-1:0] ELAPSED_TIME_OUT,
  input wire logic          DELAY_BUSY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Expiry: busy drops with elapsed time back at zero
  sequence s_done;
    $fell(DELAY_BUSY_OUT) ##0 (ELAPSED_TIME_OUT == '0);
  endsequence
  // Not disabled by reset, since reset itself is the cause
  property p_reset;
    disable iff (1'b0) SYS_RST_IN |=> !SWITCH_OUT && !DELAY_BUSY_OUT
      && ELAPSED_TIME_OUT == '0;
  endproperty
  property p_rise;
    $rose(SWITCH_OUT) |-> $past(EN_IN) ##0 s_done;
  endproperty
  property p_fall;
    $fell(SWITCH_OUT) |-> !$past(EN_IN) ##0 s_done;
  endproperty
  property p_start;
    $rose(DELAY_BUSY_OUT) |-> ELAPSED_TIME_OUT == '0
      && $past(EN_IN) != SWITCH_OUT;
  endproperty
  property p_end;
    $fell(DELAY_BUSY_OUT) |-> SWITCH_OUT == $past(EN_IN);
  endproperty
  property p_step;
    $changed(ELAPSED_TIME_OUT) && ELAPSED_TIME_OUT != '0
      |-> ELAPSED_TIME_OUT == $past(ELAPSED_TIME_OUT) + 1'b1;
  endproperty
  property p_gap;
    $changed(ELAPSED_TIME_OUT) |=> $stable(ELAPSED_TIME_OUT)[*3];
  endproperty
  property p_busy;
    ELAPSED_TIME_OUT != '0 |-> DELAY_BUSY_OUT;
  endproperty
  a_reset: assert property (p_reset) else $error("not cleared");
  a_rise: assert property (p_rise) else $error("bad rise");
  a_fall: assert property (p_fall) else $error("bad fall");
  a_start: assert property (p_start) else $error("bad start");
  a_end: assert property (p_end) else $error("bad end");
  a_step: assert property (p_step) else $error("bad step");
  a_gap: assert property (p_gap) else $error("off tick");
  a_busy: assert property (p_busy) else $error("idle count");
endmodule : rdsw_switch_assertions

bind rdsw_switch rdsw_switch_assertions #(.DW(DW)) u_rdsw_switch_assertions (
  .CLK_SYS_IN       (CLK_SYS_IN),
  .SYS_RST_IN       (SYS_RST_IN),
  .EN_IN            (EN_IN),
  .SWITCH_OUT       (SWITCH_OUT),
  .ELAPSED_TIME_OUT (ELAPSED_TIME_OUT),
  .DELAY_BUSY_OUT   (DELAY_BUSY_OUT)
);

// >>> tb/rdsw_switch_bench.sv
/*
  Self-checking bench for rdsw_switch with short timebase counts.
  Assumes the checker is bound in by its own file.
*/
module rdsw_switch_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rdsw_pkg::*;
  localparam int TBC [4] = '{4, 8, 16, 960};
  logic        clk, rst, want, en, sw, busy;
  logic [15:0] el;
  logic [255:0] blk;
  rdsw_cfg_s   cfg;
  int          mismatches, checks_done, cyc;

  rdsw_switch #(.TB_10MS_CYC(4), .TB_S_CYC(8), .TB_MIN_CYC(16))
  u_rdsw_switch (
    .CLK_SYS_IN       (clk),
    .SYS_RST_IN       (rst),
    .EN_IN            (en),
    .CFG_IN           (cfg),
    .BLK_VALUES_IN    (blk),
    .SWITCH_OUT       (sw),
    .ELAPSED_TIME_OUT (el),
    .DELAY_BUSY_OUT   (busy)
  );
  rdsw_en_src u_rdsw_en_src (
    .clk_in         (clk),
    .want_in        (want),
    .en_out         (en),
    .blk_values_out (blk)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // Hang guard well above the longest run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic setup(input int tb, input logic ub,
                       input logic [15:0] on_f, input logic [15:0] off_f);
    @(negedge clk);
    cfg = '{rdsw_tb_e'(tb[1:0]), '{ub, 4'h9, on_f}, '{ub, 4'h9, off_f}};
  endtask : setup

  task automatic go(input logic v);
    int w;
    w = 0;
    want <= v;
    while (busy !== 1'b1 && w < 2000)
    begin
      @(negedge clk);
      w++;
    end
  endtask : go

  // Busy length in cycles is (delay + 1) ticks; pk is the peak count
  task automatic measure(input logic v, output int n,
                         output logic [15:0] pk);
    n = 0;
    pk = 16'h0000;
    go(v);
    while (busy === 1'b1 && n < 3000)
    begin
      if (el > pk)
        pk = el;
      @(negedge clk);
      n++;
    end
  endtask : measure

  task automatic t_timebase();
    int n;
    logic [15:0] pk;
    for (int i = 0; i < 4; i++)
    begin
      setup(i, 1'b0, 16'h0000, 16'h0000);
      measure(1'b1, n, pk);
      chk(n == TBC[i] && sw === 1'b1, "on time");
      measure(1'b0, n, pk);
      chk(n == TBC[i] && sw === 1'b0, "off time");
    end
  endtask : t_timebase

  task automatic t_range();
    int n;
    logic [15:0] pk;
    logic [3:0]  seen;
    seen = 4'h0;
    setup(0, 1'b1, 16'hffff, 16'hffff);
    measure(1'b1, n, pk);
    chk(n == 4 && sw === 1'b1, "block on max");
    measure(1'b0, n, pk);
    chk(n == 4 && sw === 1'b0, "block off max");
    setup(0, 1'b0, 16'h0003, 16'h0003);
    repeat (6)
    begin
      measure(1'b1, n, pk);
      chk(n == 4 * (pk + 1) && pk <= 3 && sw === 1'b1, "on rnd");
      seen[pk[1:0]] = 1'b1;
      measure(1'b0, n, pk);
      chk(n == 4 * (pk + 1) && pk <= 3 && sw === 1'b0, "off rnd");
      seen[pk[1:0]] = 1'b1;
    end
    chk($countones(seen) > 1, "rnd spread");
  endtask : t_range

  // Long random delays so both aborts land well before expiry
  task automatic t_abort();
    int n;
    logic [15:0] pk;
    setup(0, 1'b0, 16'hffff, 16'h0000);
    go(1'b1);
    repeat (12) @(negedge clk);
    chk(sw === 1'b0 && el !== 16'h0000, "on run");
    go(1'b0);
    repeat (12) @(negedge clk);
    chk(sw === 1'b0 && busy === 1'b0 && el === 16'h0000, "on drop");
    setup(0, 1'b0, 16'h0000, 16'hffff);
    measure(1'b1, n, pk);
    go(1'b0);
    repeat (12) @(negedge clk);
    chk(sw === 1'b1 && busy === 1'b1, "off run");
    go(1'b1);
    repeat (12) @(negedge clk);
    chk(sw === 1'b1 && busy === 1'b0 && el === 16'h0000, "off drop");
    go(1'b0);
    repeat (12) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk(sw === 1'b0 && busy === 1'b0 && el === 16'h0000, "reset");
    rst = 1'b0;
  endtask : t_abort

  initial
  begin
    rst = 1'b1;
    want = 1'b0;
    cfg = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(sw === 1'b0 && busy === 1'b0 && el === 16'h0000, "start");
    t_timebase();
    t_range();
    t_abort();
    summarize();
  end
endmodule : rdsw_switch_bench
